// ==== common/qps_params.svh ====
`ifndef QPS_PARAMS_SVH
`define QPS_PARAMS_SVH

// register map
`define QPS_WIPER0_ADDR 5'h00
`define QPS_WIPER_LAST  5'h03
`define QPS_ACR_ADDR    5'h10

// reset values
`define QPS_WIPER_RST 8'h80
`define QPS_ACR_RST   8'h40

// control register layout
`define QPS_SHUTDOWN_N_BIT_BIT   6
`define QPS_ODRAIN_BIT 1
`define QPS_ACR_MASK   8'h42

// instruction opcodes
`define QPS_OP_NOP       3'b000
`define QPS_OP_ACR_READ  3'b001
`define QPS_OP_ACR_WRITE 3'b011
`define QPS_OP_READ      3'b100
`define QPS_OP_WRITE     3'b110
`define QPS_RB_CODE      3'b111

// link bit counter
`define QPS_CNT_ZERO 5'd0
`define QPS_CNT_MID  5'd16
`define QPS_CNT_SAT  5'd17

// supply dip filter
`define QPS_CLK_PERIOD_NS 5
`define QPS_DIP_MIN_NS    200
`define QPS_DIP_CYCLES \
  ((`QPS_DIP_MIN_NS + `QPS_CLK_PERIOD_NS - 1) / `QPS_CLK_PERIOD_NS)

`endif

// ==== common/qps_pkg.sv ====
package qps_pkg;
`include "qps_params.svh"

  // one register byte
  typedef logic [7:0] qps_byte_t;

  // instruction byte fields
  typedef struct packed {
    logic [2:0] op;
    logic [4:0] addr;
  } qps_instr_t;

  // two-byte shift path word
  typedef struct packed {
    qps_instr_t instr;
    qps_byte_t  data;
  } qps_word_t;

  // reference clock domain state
  typedef struct packed {
    logic [2:0]      cs_sync;
    logic [1:0]      dip_sync;
    logic            armed;
    logic [5:0]      dip_cnt;
    qps_byte_t [3:0] wiper;
    qps_byte_t       access_control;
  } qps_core_t;

endpackage

// ==== logic/qps_slave.sv ====
`timescale 1ns/100ps
`include "qps_params.svh"

module qps_slave
  import qps_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  input  wire logic       supply_low,
  output logic            sdo_data,
  output logic            sdo_oe,
  output qps_byte_t [3:0] wiper_pos,
  output logic            shutdown_n_bit
);

  // core state and its next value
  qps_core_t core_q;
  qps_core_t core_d;
  // link shift path and next value
  qps_word_t link_q;
  qps_word_t link_d;
  // rising edges seen in this frame
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  // output bit, falling edge flop
  logic       out_q;
  logic       out_d;
  // async clear of the frame counter
  logic       frame_clr;
  // select edges in the core domain
  logic       cs_rise;
  logic       cs_fall;
  // execute strobe at select rise
  logic       exec;
  // read-back word for the link
  qps_word_t  rb_word;
  // link word holds a read
  logic       rb_hit;
  // bit that the link would drive
  logic       head_bit;
  logic       line_bit;

  // opcode that asks for read-back
  function automatic logic is_read(input qps_word_t w);
    is_read = (w.instr.op == `QPS_OP_READ) ||
              (w.instr.op == `QPS_OP_ACR_READ);
  endfunction

  // register contents by address, zero when unmapped
  function automatic qps_byte_t reg_read(input qps_core_t c,
                                         input logic [4:0] a);
    reg_read = '0;
    if (a <= `QPS_WIPER_LAST)
      reg_read = c.wiper[a[1:0]];
    else if (a == `QPS_ACR_ADDR)
      reg_read = c.access_control & `QPS_ACR_MASK;
  endfunction

  // read-back pair: 111 plus address, then data
  function automatic qps_word_t readback(input qps_word_t w,
                                         input qps_core_t c);
    logic [4:0] a;
    a = w.instr.addr;
    // control read ignores the address field
    if (w.instr.op == `QPS_OP_ACR_READ)
      a = `QPS_ACR_ADDR;
    readback.instr.op   = `QPS_RB_CODE;
    readback.instr.addr = a;
    readback.data       = reg_read(c, a);
  endfunction

  // select edges from the synchronised copy
  assign cs_rise = core_q.cs_sync[1] & ~core_q.cs_sync[2];
  assign cs_fall = ~core_q.cs_sync[1] & core_q.cs_sync[2];
  // only after the first select fall
  assign exec    = cs_rise & core_q.armed;

  // core next state
  always_comb
  begin
    core_d          = core_q;
    // select and dip detector through two flops
    core_d.cs_sync  = {core_q.cs_sync[1:0], cs_n};
    core_d.dip_sync = {core_q.dip_sync[0], supply_low};
    // first select fall opens the link
    if (cs_fall)
    begin
      core_d.armed = 1'b1;
    end
    // last two bytes are the instruction, stable while deselected
    if (exec)
    begin
      case (link_q.instr.op)
        `QPS_OP_WRITE:
        begin
          // addressed write
          if (link_q.instr.addr <= `QPS_WIPER_LAST)
            core_d.wiper[link_q.instr.addr[1:0]] = link_q.data;
          else if (link_q.instr.addr == `QPS_ACR_ADDR)
            core_d.access_control = link_q.data & `QPS_ACR_MASK;
        end
        `QPS_OP_ACR_WRITE:
        begin
          // control write, address ignored
          core_d.access_control = link_q.data & `QPS_ACR_MASK;
        end
        default:
        begin
          // nop and reads change no register
          core_d.access_control = core_q.access_control;
        end
      endcase
    end
    // supply dip counted only in shutdown, wipers otherwise kept
    if (core_q.dip_sync[1] && !core_q.access_control[`QPS_SHUTDOWN_N_BIT_BIT])
    begin
      if (core_q.dip_cnt == 6'(`QPS_DIP_CYCLES))
      begin
        // dip long enough: back to midpoint
        for (int i = 0; i < 4; i++)
          core_d.wiper[i] = `QPS_WIPER_RST;
      end
      else
      begin
        core_d.dip_cnt = core_q.dip_cnt + 6'd1;
      end
    end
    else
    begin
      // supply good or active mode
      core_d.dip_cnt = '0;
    end
  end

  // core registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_q.cs_sync  <= 3'b000;
      core_q.dip_sync <= 2'b00;
      core_q.armed    <= 1'b0;
      core_q.dip_cnt  <= '0;
      core_q.wiper    <= {4{`QPS_WIPER_RST}};
      core_q.access_control      <= `QPS_ACR_RST;
    end
    else
    begin
      core_q <= core_d;
    end
  end

  // analog side sees stored codes and shutdown level
  assign wiper_pos      = core_q.wiper;
  assign shutdown_n_bit = core_q.access_control[`QPS_SHUTDOWN_N_BIT_BIT];

  // link side: registers are only changed around select rise or by a long supply dip in shutdown
  assign rb_word   = readback(link_q, core_q);
  assign rb_hit    = is_read(link_q);
  assign frame_clr = cs_n | ~rst_n;

  // shift path next value
  always_comb
  begin
    link_d = qps_word_t'({link_q[14:0], sdi});
    // read-back loads at frame start or after two bytes
    if (rb_hit && (cnt_q == `QPS_CNT_ZERO || cnt_q == `QPS_CNT_MID))
    begin
      link_d = qps_word_t'({rb_word[14:0], sdi});
    end
  end

  // shift path keeps its word across frames
  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_q <= '0;
    end
    else
    begin
      link_q <= link_d;
    end
  end

  // bit counter saturates past the read-back point
  always_comb
  begin
    cnt_d = cnt_q;
    if (cnt_q != `QPS_CNT_SAT)
    begin
      cnt_d = cnt_q + 5'd1;
    end
  end

  // counter cleared whenever deselected
  always_ff @(posedge sck or posedge frame_clr)
  begin
    if (frame_clr)
    begin
      cnt_q <= `QPS_CNT_ZERO;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // head bit: read-back msb or shift path msb
  assign head_bit = rb_hit ? rb_word[15] : link_q[15];

  // next output bit after this edge
  always_comb
  begin
    out_d = link_q[15];
    if (cnt_q == `QPS_CNT_MID && rb_hit)
    begin
      out_d = rb_word[15];
    end
  end

  // output changes at the falling edge
  always_ff @(negedge sck or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  // first bit of a frame stands before any falling edge
  assign line_bit = (cnt_q == `QPS_CNT_ZERO) ? head_bit : out_q;
  assign sdo_data = line_bit;

  // driver: off when deselected, open-drain only pulls low
  always_comb
  begin
    sdo_oe = 1'b0;
    if (!cs_n && core_q.armed)
    begin
      if (core_q.access_control[`QPS_ODRAIN_BIT])
        sdo_oe = ~line_bit;
      else
        sdo_oe = 1'b1;
    end
  end

  // checks in the core domain
  a_reg_init: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(rst_n) |-> core_q.wiper == {4{`QPS_WIPER_RST}})
    else $error("wiper codes not midpoint after reset");

  a_acr_init: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !$past(rst_n) |-> core_q.access_control == `QPS_ACR_RST)
    else $error("control register wrong after reset");

  a_write_commit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && link_q.instr.op == `QPS_OP_WRITE &&
     link_q.instr.addr == `QPS_WIPER0_ADDR && !core_q.dip_sync[1])
    |=> core_q.wiper[0] == $past(link_q.data))
    else $error("wiper 0 write not committed");

  a_acr_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (core_q.access_control & ~`QPS_ACR_MASK) == 8'h00)
    else $error("unused control bits set");

  a_nop_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (exec && link_q.instr.op == `QPS_OP_NOP && !core_q.dip_sync[1])
    |=> $stable(core_q.wiper) && $stable(core_q.access_control))
    else $error("nop changed a register");

  a_unarmed_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cs_rise && !core_q.armed && !core_q.dip_sync[1])
    |=> $stable(core_q.wiper) && $stable(core_q.access_control))
    else $error("executed before first select fall");

  a_shutdown_n_bit_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(core_q.access_control[`QPS_SHUTDOWN_N_BIT_BIT]) |-> $stable(core_q.wiper))
    else $error("wiper codes lost entering shutdown");

  a_dip_mid: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (core_q.dip_sync[1] && !core_q.access_control[`QPS_SHUTDOWN_N_BIT_BIT] &&
     core_q.dip_cnt == 6'(`QPS_DIP_CYCLES))
    |=> core_q.wiper == {4{`QPS_WIPER_RST}})
    else $error("dip did not recentre wipers");

  a_sdo_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cs_n |-> !sdo_oe)
    else $error("output driven while deselected");

  a_od_pull: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (core_q.access_control[`QPS_ODRAIN_BIT] && sdo_oe) |-> !sdo_data)
    else $error("open-drain drove high");

  // checks in the link domain
  a_link_shift: assert property (@(posedge sck) disable iff (!rst_n || cs_n)
    (cnt_q != `QPS_CNT_ZERO && cnt_q != `QPS_CNT_MID)
    |=> link_q == qps_word_t'({$past(link_q[14:0]), $past(sdi)}))
    else $error("shift path lost a bit");

  a_rb_head: assert property (@(negedge sck) disable iff (!rst_n || cs_n)
    (cnt_q == `QPS_CNT_MID && rb_hit) |=> out_q == 1'b1)
    else $error("read-back code missing");

  // main scenarios
  c_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
    exec && link_q.instr.op == `QPS_OP_WRITE);
  c_read_mid: cover property (@(negedge sck) disable iff (!rst_n || cs_n)
    cnt_q == `QPS_CNT_MID && rb_hit);
  c_shutdown: cover property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(core_q.access_control[`QPS_SHUTDOWN_N_BIT_BIT]));
  c_dip: cover property (@(posedge ref_clk) disable iff (!rst_n)
    core_q.dip_cnt == 6'(`QPS_DIP_CYCLES));

endmodule

// ==== test/qps_spi_master.sv ====
`timescale 1ns/100ps
module qps_spi_master
(
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo_line
);
  // idle: deselected, clock low
  initial
  begin
    sck  = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  // one frame of nb bytes, 32 ns link clock, still outside the frame
  task automatic xfer(input int nb, input logic [31:0] tx, output logic [31:0] rx);
    rx   = '0;
    cs_n = 1'b0; // frame opens with a select fall
    #20;
    for (int i = nb * 8 - 1; i >= 0; i--)
    begin
      sdi = tx[i]; // msb first, changed while clock low
      #16;
      rx[i] = sdo_line; // taken at the rising edge
      sck   = 1'b1;
      #16;
      sck = 1'b0;
    end
    sdi = ~sdi; // released line shows no stale value
    #20;
    cs_n = 1'b1; // execute at the select rise
    #2000;
  endtask
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module testbench
  import qps_pkg::*;
;
  logic            ref_clk;        // core clock
  logic            rst_n;          // async reset
  logic            supply_low;     // dip detector
  logic            sck;            // link clock
  logic            cs_n;           // select
  logic            sdi;            // serial in
  logic            sdo_data;       // serial out bit
  logic            sdo_oe;         // serial out enable
  wire             sdo_line;       // resolved serial wire
  qps_byte_t [3:0] wiper_pos;      // wiper codes
  logic            shutdown_n_bit; // active channels
  qps_byte_t [3:0] exp_w;          // expected wipers
  qps_byte_t       exp_acr;        // expected control
  logic [31:0]     rx;             // received frame
  int              n_mismatch;
  int              checked;

  // pull-up only in open-drain mode, else floating
  assign sdo_line = sdo_oe ? sdo_data : (exp_acr[1] ? 1'b1 : 1'bz);

  qps_slave i_qps_slave (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .sck            (sck),
    .cs_n           (cs_n),
    .sdi            (sdi),
    .supply_low     (supply_low),
    .sdo_data       (sdo_data),
    .sdo_oe         (sdo_oe),
    .wiper_pos      (wiper_pos),
    .shutdown_n_bit (shutdown_n_bit)
  );

  qps_spi_master i_qps_spi_master (
    .sck      (sck),
    .cs_n     (cs_n),
    .sdi      (sdi),
    .sdo_line (sdo_line)
  );

  // core clock
  always #2.5 ref_clk = ~ref_clk;

  // register outputs against the expected copy
  task chk_regs;
    for (int i = 0; i < 4; i++)
      `CHK(wiper_pos[i], exp_w[i])
    `CHK(shutdown_n_bit, exp_acr[6])
    `CHK(sdo_oe, 1'b0)
  endtask

  // two-byte frame
  task wr(input qps_byte_t ins, input qps_byte_t dat);
    i_qps_spi_master.xfer(2, {16'h0, ins, dat}, rx);
  endtask

  // hold the dip input for n core cycles
  task dip(input int n);
    @(negedge ref_clk);
    supply_low = 1'b1;
    repeat (n) @(negedge ref_clk);
    supply_low = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  task t_write;
    qps_byte_t vals [4];
    qps_byte_t bad [4];
    vals = '{8'h00, 8'h5a, 8'ha5, 8'hff};
    bad  = '{8'hc5, 8'h40, 8'ha0, 8'he0};
    for (int i = 0; i < 4; i++)
    begin
      wr({3'b110, 5'(i)}, vals[i]);
      exp_w[i] = vals[i];
    end
    chk_regs();
    i_qps_spi_master.xfer(4, 32'hc1_11_c2_3c, rx);
    `CHK(rx, {8'hc3, vals[3], 16'hc1_11})
    exp_w[2] = 8'h3c;
    chk_regs();
    for (int i = 0; i < 4; i++)
      wr(bad[i], 8'h77);
    chk_regs();
    $display("test write done");
  endtask

  task t_read;
    logic [4:0] a;
    for (int i = 0; i < 5; i++)
    begin
      a = (i == 4) ? 5'h05 : 5'(i);
      i_qps_spi_master.xfer(4, {3'b100, a, 24'h0}, rx);
      `CHK(rx[15:0], {3'b111, a, (i == 4) ? 8'h00 : exp_w[i]})
    end
    wr(8'h83, 8'h00);
    wr(8'h00, 8'h00);
    `CHK(rx[15:0], {8'he3, exp_w[3]})
    $display("test read done");
  endtask

  task t_control;
    wr(8'h7f, 8'hff);
    exp_acr = 8'h42;
    chk_regs();
    i_qps_spi_master.xfer(4, 32'h20_00_00_00, rx);
    `CHK(rx[15:0], 16'hf0_42)
    i_qps_spi_master.xfer(4, 32'h90_00_00_00, rx);
    `CHK(rx[15:0], 16'hf0_42)
    i_qps_spi_master.xfer(4, 32'h81_00_00_00, rx);
    `CHK(rx[15:0], {8'he1, exp_w[1]})
    wr(8'hd0, 8'h00);
    exp_acr = 8'h00;
    chk_regs();
    $display("test control done");
  endtask

  task t_dip;
    dip(60);
    exp_w = {4{8'h80}};
    chk_regs();
    wr(8'h70, 8'h40);
    wr(8'hc0, 8'h55);
    exp_acr  = 8'h40;
    exp_w[0] = 8'h55;
    dip(60);
    chk_regs();
    $display("test dip done");
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard
  initial
  begin
    #400000;
    n_mismatch++;
    stop_test();
  end

  // main sequence
  initial
  begin
    ref_clk    = 1'b0;
    rst_n      = 1'b0;
    supply_low = 1'b0;
    n_mismatch = 0;
    checked    = 0;
    exp_w      = {4{8'h80}};
    exp_acr    = 8'h40;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (10) @(negedge ref_clk);
    chk_regs();
    t_write();
    t_read();
    t_control();
    t_dip();
    stop_test();
  end
endmodule
